// ==== rps_check_sva.sv ====
`timescale 1ns/1ps
// port-level checks of the reset pin sequencer
module rps_check
    import rps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire rps_int_req_t int_req,
    input wire logic pin_in,
    input wire logic stop_self_clk_sel,
    input wire logic stop_recovery,
    input wire logic pin_oe,
    input wire logic pin_pullup,
    input wire logic system_options_one,
    input wire logic [CAUSE_W-1:0] reset_cause_status,
    input wire logic system_reset,
    input wire logic self_clk_select
);
    localparam int W_LO = WAIT_CYCLES - 2;
    localparam int W_HI = WAIT_CYCLES + 3;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] oe_cnt; // length of the current reset drive
    // counts only in-sequence drive, port mode drives forever
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) oe_cnt <= 8'h00;
        else oe_cnt <= (pin_oe && system_reset) ? oe_cnt + 8'h01 : 8'h00;
    end
    a_int_starts_drive: assert property (!system_reset && |int_req
        |=> system_reset && pin_oe) else $error("no drive on request");
    a_pin_starts_reset: assert property ($fell(pin_in) &&
        system_options_one && !system_reset |-> ##[2:4] system_reset)
        else $error("low pin ignored");
    a_port_holds: assert property (!system_options_one &&
        !system_reset && int_req == 3'h0 |=> !system_reset)
        else $error("port mode reset");
    a_pullup_follows: assert property (
        pin_pullup == $past(system_options_one)) else $error("pullup");
    a_drive_length: assert property ($fell(pin_oe) && system_reset
        |-> oe_cnt >= DRIVE_LOAD && oe_cnt <= DRIVE_LOAD + 8'h02)
        else $error("drive length");
    a_wait_resample: assert property ($fell(pin_oe) && system_reset
        |-> ##[W_LO:W_HI] $fell(system_reset)) else $error("wait length");
    a_cause_single: assert property ($fell(system_reset)
        |-> $onehot(reset_cause_status[7:1])) else $error("cause bits");
    a_stop_clock: assert property (stop_self_clk_sel && stop_recovery
        |=> self_clk_select) else $error("self clock");
    cover property ($fell(system_reset));
    cover property (!system_options_one && pin_oe);
    cover property ($rose(self_clk_select));
endmodule // rps_check

// ==== rps_pin_model.sv ====
`timescale 1ns/1ps
// far side of the shared pin: an external reset source
module rps_pin_model (
    input wire logic ref_clk,
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic pin_pullup,
    input wire logic ext_low,
    output logic pin_level
);
    logic last = 1'b1; // wire level seen last cycle
    always @(posedge ref_clk) last <= pin_level;
    // device drive wins; a floating pin flips so stale data never passes
    always_comb begin
        if (pin_oe) pin_level = pin_out;
        else if (ext_low) pin_level = 1'b0;
        else pin_level = pin_pullup ? 1'b1 : ~last;
    end
endmodule // rps_pin_model

// ==== rps_pkg.sv ====
package rps_pkg;
    // self-clock rate and reset pin timing
    localparam int SELF_CLK_KHZ = 8000;     // self-clocked source, ~8 MHz
    localparam int REF_CLK_KHZ = 25000;     // ref_clk rate
    localparam int DRIVE_SELF_CYCLES = 34;  // pin held low, self cycles
    localparam int WAIT_SELF_CYCLES = 38;   // wait before resample
    // self-clock cycles converted to ref_clk cycles (drive is a least time)
    localparam int DRIVE_CYCLES =
        (DRIVE_SELF_CYCLES * REF_CLK_KHZ + SELF_CLK_KHZ - 1) / SELF_CLK_KHZ;
    localparam int WAIT_CYCLES =
        (WAIT_SELF_CYCLES * REF_CLK_KHZ + SELF_CLK_KHZ - 1) / SELF_CLK_KHZ;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] DRIVE_LOAD = CNT_W'(DRIVE_CYCLES - 1);
    localparam logic [CNT_W-1:0] WAIT_LOAD = CNT_W'(WAIT_CYCLES - 1);

    // reset cause status bit positions
    localparam int CAUSE_W = 8;
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_PIN = 6;
    localparam int CAUSE_COP = 5;
    localparam int CAUSE_ILOP = 4;
    localparam int CAUSE_LVD = 1;
    localparam int CAUSE_PIN_FAIL = 0;      // internal reset, pin read low
    localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL = 8'h80;

    // internal reset request sources
    typedef struct packed {
        logic low_voltage;
        logic watchdog;
        logic illegal_op;
    } rps_int_req_t;

    typedef enum logic [1:0] {
        RPS_RUN = 2'b00,
        RPS_DRIVE = 2'b01,
        RPS_WAIT = 2'b10,
        RPS_SAMPLE = 2'b11
    } rps_state_t;
endpackage

// ==== rps_reset_pin.sv ====
`timescale 1ns/1ps
// What this block does
// (R1) power-on makes shared pin the reset input
// (R2) clearing reset_pin_enable makes pin output-only port
// (R3) port function holds until next reset
// (R4) low pin in reset mode causes reset
// (R5) pullup on while reset_pin_enable is one
// (R6) power-on into background mode keeps reset pin
// (R7) any reset drives pin low 34 self cycles
// (R8) after release wait 38 cycles, resample
// (R9) internal reset expects the resample high
// (R10) record decoded cause in status register
// (R11) self-clocked source runs during reset startup
// (R12) self-clock selectable for stop recovery
// (R13) status holds only the latest cause
module rps_reset_pin
    import rps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic por_event,
    input wire logic bgnd_mode,
    input wire rps_int_req_t int_req,
    input wire logic opt_write,
    input wire logic opt_reset_pin_enable,
    input wire logic port_b_bit_two,
    input wire logic pin_in,
    input wire logic stop_self_clk_sel,
    input wire logic stop_recovery,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_pullup,
    output logic system_options_one,
    output logic [CAUSE_W-1:0] reset_cause_status,
    output logic system_reset,
    output logic self_clk_select
);
    logic pin_sync; // pin level after two flops
    rps_state_t state; // reset sequence state
    logic [CNT_W-1:0] count; // cycles left in drive or wait phase
    logic internal_cause; // current reset came from inside
    logic [CAUSE_W-1:0] pending_cause; // cause captured at trigger
    logic any_int; // any internal request
    logic pin_reset; // external pin pulled low in reset mode
    logic trigger; // start a new reset sequence

    rps_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    assign any_int = int_req.low_voltage | int_req.watchdog
        | int_req.illegal_op;
    // pin only counts as reset while configured so and idle
    assign pin_reset = system_options_one && !pin_sync
        && (state == RPS_RUN); // R4
    assign trigger = (state == RPS_RUN) && (any_int || pin_reset);

    // pin function select: reset input after any reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_options_one <= 1'b1; // R1 R6
        end else if (state != RPS_RUN) begin
            // every reset restores the reset function
            system_options_one <= 1'b1; // R3
        end else if (opt_write && !opt_reset_pin_enable) begin
            // one-way: software cannot set it back, only a reset does
            system_options_one <= 1'b0; // R2 R3
        end
    end

    // reset sequence: drive low, release, wait, resample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= RPS_DRIVE; // power-on also runs the sequence
            count <= DRIVE_LOAD;
        end else begin
            unique case (state)
                RPS_RUN: begin
                    if (trigger) begin
                        state <= RPS_DRIVE; // R7
                        count <= DRIVE_LOAD;
                    end
                end
                RPS_DRIVE: begin
                    if (count == CNT_ZERO) begin
                        state <= RPS_WAIT; // R8
                        count <= WAIT_LOAD;
                    end else begin
                        count <= count - CNT_ONE; // R7
                    end
                end
                RPS_WAIT: begin
                    if (count == CNT_ZERO) begin
                        state <= RPS_SAMPLE; // R8
                    end else begin
                        count <= count - CNT_ONE;
                    end
                end
                RPS_SAMPLE: begin
                    state <= RPS_RUN;
                    count <= CNT_ZERO;
                end
            endcase
        end
    end

    // capture the cause when the sequence starts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending_cause <= CAUSE_POR_VAL;
            internal_cause <= 1'b1; // power-on counts as internal
        end else if (trigger) begin
            // priority: low voltage, watchdog, illegal op, then pin
            pending_cause <= '0; // R13
            internal_cause <= any_int;
            if (int_req.low_voltage) begin
                pending_cause[CAUSE_LVD] <= 1'b1; // R10
            end else if (int_req.watchdog) begin
                pending_cause[CAUSE_COP] <= 1'b1; // R10
            end else if (int_req.illegal_op) begin
                pending_cause[CAUSE_ILOP] <= 1'b1; // R10
            end else begin
                pending_cause[CAUSE_PIN] <= 1'b1; // R10
            end
        end
    end

    // status register: replaced whole at each resample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reset_cause_status <= '0;
        end else if (state == RPS_SAMPLE) begin
            reset_cause_status <= pending_cause; // R10 R13
            if (internal_cause && !pin_sync) begin
                // pin held low by outside: flag the failed check
                reset_cause_status[CAUSE_PIN_FAIL] <= 1'b1; // R9
            end
        end
    end

    // pin drivers: low during drive phase, else port data if enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b1;
            pin_pullup <= 1'b1;
        end else begin
            if (trigger || (state == RPS_DRIVE && count != CNT_ZERO)) begin
                pin_out <= 1'b0; // R7
                pin_oe <= 1'b1;
            end else if (state == RPS_RUN && !system_options_one) begin
                pin_out <= port_b_bit_two; // R2
                pin_oe <= 1'b1;
            end else begin
                pin_out <= 1'b0;
                pin_oe <= 1'b0; // released
            end
            pin_pullup <= system_options_one; // R5
        end
    end

    // system reset out and clock select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_reset <= 1'b1;
            self_clk_select <= 1'b1;
        end else begin
            system_reset <= trigger || (state != RPS_RUN
                && state != RPS_SAMPLE); // R4
            // self clock during startup, or on stop recovery if chosen
            self_clk_select <= trigger || (state != RPS_RUN
                && state != RPS_SAMPLE) // R11
                || (stop_recovery && stop_self_clk_sel); // R12
        end
    end
endmodule // rps_reset_pin

// ==== rps_reset_pin_bench.sv ====
`timescale 1ns/1ps
module rps_reset_pin_bench;
    import rps_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, bg = 1'b0, wr = 1'b0, en = 1'b1;
    logic pb = 1'b0, sel = 1'b0, rec = 1'b0, ext = 1'b0, lvl;
    logic p_out, p_oe, pull, opt, srst, csel;
    rps_int_req_t req = 3'h0; // internal requests
    logic [CAUSE_W-1:0] st;
    int num_errors = 0;
    int checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    rps_reset_pin dut (.ref_clk(ref_clk), .rst(rst), .por_event(1'b0),
        .bgnd_mode(bg), .int_req(req), .opt_write(wr),
        .opt_reset_pin_enable(en), .port_b_bit_two(pb), .pin_in(lvl),
        .stop_self_clk_sel(sel), .stop_recovery(rec), .pin_out(p_out),
        .pin_oe(p_oe), .pin_pullup(pull), .system_options_one(opt),
        .reset_cause_status(st), .system_reset(srst),
        .self_clk_select(csel));
    rps_pin_model far (.ref_clk(ref_clk), .pin_oe(p_oe), .pin_out(p_out),
        .pin_pullup(pull), .ext_low(ext), .pin_level(lvl));
    task chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for the sequence to end; a hang ends the run
    task wait_idle;
        int n;
        n = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        while (srst !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 400) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task t_power(input logic b);
        @(posedge ref_clk) begin rst <= 1'b1; bg <= b; end
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        wait_idle();
        chk(st, CAUSE_POR_VAL, "por cause");
        chk({6'h0, opt, pull}, 8'h03, "pin mode");
        $display("power test done");
    endtask
    task t_internal;
        rps_int_req_t r [4] = '{3'h4, 3'h2, 3'h1, 3'h7};
        logic [7:0] e [4] = '{8'h02, 8'h20, 8'h10, 8'h02};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) req <= r[i];
            @(posedge ref_clk) req <= 3'h0;
            wait_idle();
            chk(st, e[i], "internal cause");
        end
        $display("internal test done");
    endtask
    task t_pin;
        @(posedge ref_clk) ext <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ext <= 1'b0;
        wait_idle();
        chk(st, 8'h40, "pin cause");
        $display("pin test done");
    endtask
    task t_port;
        @(posedge ref_clk) begin wr <= 1'b1; en <= 1'b0; pb <= 1'b1; end
        @(posedge ref_clk) wr <= 1'b0;
        repeat (2) @(posedge ref_clk) ext <= 1'b1;
        #1;
        chk({4'h0, opt, pull, p_oe, p_out}, 8'h03, "port mode");
        repeat (20) @(posedge ref_clk);
        #1;
        chk({7'h0, srst}, 8'h00, "pin ignored");
        @(posedge ref_clk) begin ext <= 1'b0; req <= 3'h2; en <= 1'b1; end
        @(posedge ref_clk) req <= 3'h0;
        wait_idle();
        chk({7'h0, opt}, 8'h01, "pin mode back");
        $display("port test done");
    endtask
    task t_fail;
        @(posedge ref_clk) begin ext <= 1'b1; req <= 3'h2; end
        @(posedge ref_clk) req <= 3'h0;
        wait_idle();
        chk({7'h0, st[CAUSE_PIN_FAIL]}, 8'h01, "resample low");
        // the pin is still held low, so a pin reset follows at once
        @(posedge ref_clk) ext <= 1'b0;
        wait_idle();
        chk({7'h0, csel}, 8'h00, "clock back");
        // stop recovery while idle, so only the select can raise it
        @(posedge ref_clk) begin sel <= 1'b1; rec <= 1'b1; end
        @(posedge ref_clk) begin sel <= 1'b0; rec <= 1'b0; end
        #1;
        chk({7'h0, csel}, 8'h01, "self clock");
        @(posedge ref_clk);
        #1;
        chk({7'h0, csel}, 8'h00, "self clock off");
        $display("fail test done");
    endtask
    initial begin
        t_power(1'b0);
        t_internal();
        t_pin();
        t_port();
        t_fail();
        t_power(1'b1);
        tally_and_finish();
    end
endmodule // rps_reset_pin_bench
bind rps_reset_pin rps_check u_chk (.*);

// ==== rps_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for the reset pin level
module rps_sync
    import rps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage_one; // read only by the second stage

    // preset high: the pin idles high through its pullup
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage_one <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule // rps_sync
